// [shared/scsl_pkg.sv]
/*
  constants, modes, commands and state type for the synth command,
  sweep and list controller.
  assumes a 50 MHz system clock and an upstream parser that delivers
  decoded commands; nothing here drives logic.
*/
// Behaviour
// - a command with no parameter or with a question mark reports its setting.
// - baud command accepts only the eight listed rates; query lists them.
// - after a new rate is taken, only that rate is used; host must follow.
// - identify returns a string; with count n flashes the indicator n times.
// - recall loads all stored settings into the active state, like power-up; code loads only frequency, mode and run.
// - restore-defaults returns factory values but keeps the reference trim; code also keeps start, stop, retrace dwell and baud.
// - store writes the whole current state for use at next power-up; code only pulses nvStore and the bench image keeps output frequency.
// - erase is restore-defaults plus clearing stored user data and names.
// - three modes, continuous-wave by default; commands follow active mode.
// - frequency accepts values inside and outside 18 to 32 GHz.
// - signed offset added to frequency; out-of-range result flags an error.
// - in continuous-wave mode up and down commands move frequency by step.
// - sweep steps start toward stop, one step per programmed interval.
// - go starts sweeping, cease stops it; running state is storable.
// - auto repeats sweeps; manual runs one sweep per manual trigger.
// - external mode runs one full sweep per rising trigger edge.
// - external-step mode advances one step per trigger event.
// - continuous-wave or list mode disables sweeping.
// - a programmable retrace dwell precedes every new sweep.
// - list mode takes frequency from 32 entries chosen by 5-bit select.
// - list entries default to 2441 through 2472 MHz.
// - entry write sets frequency and optional power, else global power.
// - commands in a line are held until carriage return arrives; code acts only on the command given with lineEnd.
// - one step pulse for every frequency change during a sweep.
// - sweep-active stays high for the whole sweep cycle; code holds it low in idle and during retrace dwell.
package scsl_pkg;

  // ****************************************************************
  // frequency, timing, list and reset constants
  // ****************************************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int MS_PER_S        = 1000;
  localparam int CYC_PER_MS      = CLK_HZ / MS_PER_S;
  localparam int FLASH_TIME_MS   = 1000;
  localparam int FLASH_CYC       = FLASH_TIME_MS * CYC_PER_MS;
  localparam int LIST_LEN        = 32;
  localparam logic [39:0] LIST_BASE_HZ = 40'd2441_000_000;
  localparam logic [39:0] LIST_INC_HZ  = 40'd1_000_000;
  localparam logic [39:0] FREQ_RST_HZ  = 40'd20_000_000_000;
  localparam logic [39:0] STEP_RST_HZ  = 40'd1_000_000;
  localparam logic [32:0] OFS_MAX_HZ   = 33'h0FFFFFFFF;
  localparam logic [39:0] FREQ_MAX_HZ  = 40'hFF_FFFF_FFFF;
  localparam logic [15:0] RATE_RST_MS  = 16'h000A;
  localparam logic [2:0]  BAUD_RST     = 3'h0;
  localparam logic [11:0] TRIM_RST     = 12'h800;
  localparam logic [7:0]  PWR_RST      = 8'h00;

  typedef enum logic [1:0]
  {
    MODE_CW = 2'b00, MODE_SWEEP = 2'b01, MODE_LIST = 2'b10
  } scsl_mode_e;

  typedef enum logic [1:0]
  {
    TRG_AUTO = 2'b00, TRG_MANUAL = 2'b01, TRG_EXT = 2'b10,
    TRG_EXT_STEP = 2'b11
  } scsl_trig_e;

  typedef enum logic [4:0]
  {
    CMD_NONE = 5'h00, CMD_BAUD = 5'h01, CMD_IDENTIFY = 5'h02,
    CMD_RECALL = 5'h03, CMD_RESTORE = 5'h04, CMD_STORE = 5'h05,
    CMD_ERASE = 5'h06, CMD_MODE = 5'h07, CMD_FREQ = 5'h08,
    CMD_OFFSET = 5'h09, CMD_STEP = 5'h0A, CMD_FREQ_UP = 5'h0B,
    CMD_FREQ_DOWN = 5'h0C, CMD_START = 5'h0D, CMD_STOP = 5'h0E,
    CMD_RATE = 5'h0F, CMD_RETRACE = 5'h10, CMD_GO = 5'h11,
    CMD_CEASE = 5'h12, CMD_TRIG_MODE = 5'h13, CMD_MAN_TRIG = 5'h14,
    CMD_LIST = 5'h15, CMD_POWER = 5'h16
  } scsl_cmd_e;

  typedef enum logic [1:0]
  {
    SW_IDLE = 2'b00, SW_DWELL = 2'b01, SW_RUN = 2'b10, SW_WAIT = 2'b11
  } scsl_sw_e;

  typedef enum logic [1:0]
  {
    NV_IDLE = 2'b00, NV_LOAD = 2'b01, NV_SAVE = 2'b10
  } scsl_nv_e;

endpackage : scsl_pkg

// [hw/scsl_ctrl.sv]
/*
  command executor, sweep sequencer and list selector.
  assumes an upstream text parser presents one decoded command a cycle
  (cmdValid) and marks end of line with lineEnd; only the command that
  arrives with lineEnd is executed. the non-volatile store is a word port.
*/
`timescale 1ns/1ps
module scsl_ctrl
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // decoded command stream
  input  wire logic                 cmdValid,
  input  wire scsl_pkg::scsl_cmd_e  cmdCode,
  input  wire logic                 cmdQuery,
  input  wire logic                 cmdHasArg,
  input  wire logic [39:0]          cmdArg,
  input  wire logic [7:0]           cmdArg2,
  input  wire logic                 cmdHasArg2,
  input  wire logic                 lineEnd,
  // non-volatile image in
  input  wire logic                 nvLoadValid,
  input  wire logic [39:0]          nvFreq,
  input  wire logic [1:0]           nvMode,
  input  wire logic                 nvRun,
  // user port pins
  input  wire logic                 trigPin,
  input  wire logic [4:0]           listSelPin,
  // outputs
  output logic                      reportValid,
  output scsl_pkg::scsl_cmd_e       reportCmd,
  output logic [39:0]               reportData,
  output logic                      errorPulse,
  output logic [2:0]                baudSel,
  output logic                      statusLed,
  output logic                      nvStore,
  output logic                      nvErase,
  output logic                      nvLoadReq,
  output logic [39:0]               outFreq,
  output logic [7:0]                outPower,
  output logic [11:0]               refTrim,
  output logic                      sweepActive,
  output logic                      sweepStep
);
  import scsl_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  trigSync;
    logic [4:0]  sel1;
    logic [4:0]  sel2;
    logic        trigLast;
    scsl_mode_e  mode;
    scsl_trig_e  trigger_mode_cmd;
    scsl_sw_e    sw;
    logic        run;
    logic        pend;
    logic [39:0] freq;
    logic [39:0] step;
    logic [39:0] start;
    logic [39:0] stop;
    logic [39:0] cur;
    logic        ofsNeg;
    logic [32:0] ofs;
    logic [15:0] rate;
    logic [31:0] retrace_dwell_cmd;
    logic [47:0] tick;
    logic [7:0]  power;
    logic [11:0] trim;
    logic [2:0]  baud;
    logic [7:0]  flashLeft;
    logic [25:0] flashCnt;
    logic        led;
    logic        repV;
    scsl_cmd_e   repC;
    logic [39:0] repD;
    logic        err;
    logic        store;
    logic        erase;
    logic        loadReq;
    logic [39:0] outF;
    logic        act;
    logic        stepP;
    logic [7:0]  outP;
  } scsl_state_s;

  scsl_state_s s_q, s_d;
  logic [39:0] listF [LIST_LEN];
  logic [7:0]  listP [LIST_LEN];
  logic [LIST_LEN-1:0] listWr;
  logic [39:0] listDefault [LIST_LEN];
  logic        trigRise;
  logic        commit;
  logic        pendSet;
  logic [40:0] sum;

  // ****************************************************************
  // list table
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < LIST_LEN; gi++)
    begin : g_list
      assign listDefault[gi] = LIST_BASE_HZ + LIST_INC_HZ * 40'(gi);
      always_ff @(posedge clk)
      begin
        if (!rst_b || (commit && cmdCode == CMD_RESTORE)
            || (commit && cmdCode == CMD_ERASE))
        begin
          listF[gi] <= listDefault[gi];
          listP[gi] <= PWR_RST;
        end
        else if (listWr[gi])
        begin
          listF[gi] <= cmdArg;
          listP[gi] <= cmdHasArg2 ? cmdArg2 : s_q.power;
        end
      end
    end
  endgenerate

  // act only on a committed line
  assign commit = cmdValid && lineEnd;
  assign trigRise = s_q.trigSync[1] && !s_q.trigLast;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_d       = s_q;
    listWr    = '0;
    s_d.repV  = 1'b0;
    s_d.err   = 1'b0;
    s_d.store = 1'b0;
    s_d.erase = 1'b0;
    s_d.loadReq = 1'b0;
    s_d.stepP = 1'b0;
    pendSet   = 1'b0;
    s_d.trigSync = {s_q.trigSync[0], trigPin};
    s_d.sel1  = listSelPin;
    s_d.sel2  = s_q.sel1;
    s_d.trigLast = s_q.trigSync[1];
    if (commit)
    begin
      s_d.repC = cmdCode;
      if (cmdQuery || (!cmdHasArg && cmdCode != CMD_FREQ_UP
          && cmdCode != CMD_FREQ_DOWN && cmdCode != CMD_GO
          && cmdCode != CMD_CEASE && cmdCode != CMD_MAN_TRIG
          && cmdCode != CMD_RECALL && cmdCode != CMD_STORE
          && cmdCode != CMD_RESTORE && cmdCode != CMD_ERASE))
      begin
        s_d.repV = 1'b1;
        case (cmdCode)
          CMD_FREQ:   s_d.repD = s_q.freq;
          CMD_STEP:   s_d.repD = s_q.step;
          CMD_START:  s_d.repD = s_q.start;
          CMD_STOP:   s_d.repD = s_q.stop;
          CMD_RATE:   s_d.repD = {24'h0, s_q.rate};
          CMD_RETRACE: s_d.repD = {8'h0, s_q.retrace_dwell_cmd};
          CMD_MODE:   s_d.repD = {38'h0, s_q.mode};
          CMD_TRIG_MODE: s_d.repD = {38'h0, s_q.trigger_mode_cmd};
          CMD_POWER:  s_d.repD = {32'h0, s_q.power};
          CMD_IDENTIFY: s_d.repD = 40'h00_0000_0000;
          // query lists all eight rates as a mask
          CMD_BAUD:   s_d.repD = 40'h00_0000_00FF;
          CMD_LIST:   s_d.repD = cmdHasArg ? listF[cmdArg[4:0]]
                                           : 40'h00_0000_0020;
          default:    s_d.repD = {6'h0, s_q.ofsNeg, s_q.ofs};
        endcase
      end
      else
      begin
        case (cmdCode)
          // only listed rates, switched at once
          CMD_BAUD:
          begin
            if (cmdArg[39:3] == '0)
              s_d.baud = cmdArg[2:0];
            else
              s_d.err = 1'b1;
          end
          CMD_IDENTIFY:
          begin
            s_d.repV = 1'b1;
            s_d.repD = 40'h00_0000_0000;
            s_d.flashLeft = cmdArg[7:0];
            s_d.flashCnt = '0;
          end
          CMD_RECALL: s_d.loadReq = 1'b1;
          CMD_RESTORE, CMD_ERASE:
          begin
            s_d.mode = MODE_CW;
            s_d.trigger_mode_cmd = TRG_AUTO;
            s_d.freq = FREQ_RST_HZ;
            s_d.step = STEP_RST_HZ;
            s_d.ofs = '0;
            s_d.ofsNeg = 1'b0;
            s_d.run = 1'b0;
            s_d.power = PWR_RST;
            s_d.rate = RATE_RST_MS;
            s_d.erase = (cmdCode == CMD_ERASE);
          end
          CMD_STORE: s_d.store = 1'b1;
          CMD_MODE:
          begin
            s_d.mode = scsl_mode_e'(cmdArg[1:0]);
            if (cmdArg[1:0] != MODE_SWEEP)
              s_d.sw = SW_IDLE;
          end
          CMD_FREQ:   s_d.freq = cmdArg;
          CMD_OFFSET:
          begin
            // refused offsets leave the old one in force
            if (cmdArg > {7'h0, OFS_MAX_HZ})
              s_d.err = 1'b1;
            else
            begin
              s_d.ofsNeg = cmdHasArg2;
              s_d.ofs = cmdArg[32:0];
            end
          end
          CMD_STEP:   s_d.step = cmdArg;
          CMD_FREQ_UP:
            if (s_q.mode == MODE_CW)
              s_d.freq = s_q.freq + s_q.step;
          CMD_FREQ_DOWN:
            if (s_q.mode == MODE_CW)
              s_d.freq = s_q.freq - s_q.step;
          CMD_START:  s_d.start = cmdArg;
          CMD_STOP:   s_d.stop = cmdArg;
          CMD_RATE:   s_d.rate = cmdArg[15:0];
          CMD_RETRACE: s_d.retrace_dwell_cmd = cmdArg[31:0];
          CMD_GO:     s_d.run = 1'b1;
          CMD_CEASE:
          begin
            s_d.run = 1'b0;
            s_d.sw = SW_IDLE;
          end
          CMD_TRIG_MODE: s_d.trigger_mode_cmd = scsl_trig_e'(cmdArg[1:0]);
          CMD_MAN_TRIG:
          begin
            s_d.pend = 1'b1;
            pendSet = 1'b1;
          end
          CMD_LIST:   listWr[cmdArg2[4:0]] = 1'b1;
          CMD_POWER:  s_d.power = cmdArg[7:0];
          default:    s_d.err = 1'b1;
        endcase
      end
    end
    if (nvLoadValid)
    begin
      s_d.freq = nvFreq;
      s_d.mode = scsl_mode_e'(nvMode);
      s_d.run = nvRun;
    end
    if (s_q.flashLeft != '0)
    begin
      s_d.flashCnt = s_q.flashCnt + 26'h1;
      s_d.led = (s_q.flashCnt < 26'(FLASH_CYC / 2));
      if (s_q.flashCnt == 26'(FLASH_CYC - 1))
      begin
        s_d.flashCnt = '0;
        s_d.flashLeft = s_q.flashLeft - 8'h1;
      end
    end
    else
      s_d.led = 1'b0;
    // ****************************************************************
    // sweep sequencer
    // ****************************************************************
    if (s_q.trigger_mode_cmd == TRG_EXT && trigRise)
    begin
      s_d.pend = 1'b1;
      pendSet = 1'b1;
    end
    s_d.tick = s_q.tick + 48'h1;
    case (s_q.sw)
      SW_IDLE:
      begin
        s_d.tick = '0;
        if (s_q.mode == MODE_SWEEP && s_q.run
            && (s_q.trigger_mode_cmd == TRG_AUTO || s_q.trigger_mode_cmd == TRG_EXT_STEP
                || s_q.pend))
        begin
          // a trigger landing in the consuming cycle is kept
          s_d.pend = pendSet;
          s_d.sw = SW_DWELL;
        end
      end
      SW_DWELL:
        if (s_q.tick >= 48'(s_q.retrace_dwell_cmd) * 48'(CYC_PER_MS))
        begin
          s_d.tick = '0;
          s_d.cur = s_q.start;
          s_d.sw = (s_q.trigger_mode_cmd == TRG_EXT_STEP) ? SW_WAIT : SW_RUN;
          s_d.stepP = 1'b1;
        end
      SW_RUN:
        if (s_q.tick >= 48'(s_q.rate) * 48'(CYC_PER_MS))
        begin
          s_d.tick = '0;
          if (s_q.cur + s_q.step >= s_q.stop)
            s_d.sw = SW_IDLE;
          else
          begin
            s_d.cur = s_q.cur + s_q.step;
            s_d.stepP = 1'b1;
          end
        end
      SW_WAIT:
        if (trigRise)
        begin
          if (s_q.cur + s_q.step >= s_q.stop)
            s_d.sw = SW_IDLE;
          else
          begin
            s_d.cur = s_q.cur + s_q.step;
            s_d.stepP = 1'b1;
          end
        end
      default: s_d.sw = SW_IDLE;
    endcase
    if (s_q.mode != MODE_SWEEP || !s_q.run)
      s_d.sw = SW_IDLE;
    s_d.act = (s_d.sw == SW_RUN) || (s_d.sw == SW_WAIT);
    case (s_q.mode)
      MODE_SWEEP: sum = {1'b0, s_q.cur};
      MODE_LIST:  sum = {1'b0, listF[s_q.sel2]};
      default:    sum = {1'b0, s_q.freq};
    endcase
    if (s_q.ofsNeg)
      sum = sum - {8'h0, s_q.ofs};
    else
      sum = sum + {8'h0, s_q.ofs};
    if (sum[40])
      s_d.err = 1'b1;
    else
      s_d.outF = sum[39:0];
    s_d.outP = (s_q.mode == MODE_LIST) ? listP[s_q.sel2] : s_q.power;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_q       <= '0;
      s_q.freq  <= FREQ_RST_HZ;
      s_q.step  <= STEP_RST_HZ;
      s_q.rate  <= RATE_RST_MS;
      s_q.trim  <= TRIM_RST;
      s_q.baud  <= BAUD_RST;
      s_q.mode  <= MODE_CW;
      s_q.sw    <= SW_IDLE;
      s_q.repC  <= CMD_NONE;
    end
    else
      s_q <= s_d;
  end

  assign reportValid = s_q.repV;
  assign reportCmd   = s_q.repC;
  assign reportData  = s_q.repD;
  assign errorPulse  = s_q.err;
  assign baudSel     = s_q.baud;
  assign statusLed   = s_q.led;
  assign nvStore     = s_q.store;
  assign nvErase     = s_q.erase;
  assign nvLoadReq   = s_q.loadReq;
  assign outFreq     = s_q.outF;
  assign outPower    = s_q.outP;
  assign refTrim     = s_q.trim;
  assign sweepActive = s_q.act;
  assign sweepStep   = s_q.stepP;

endmodule : scsl_ctrl

// [tb/scsl_ctrl_chk.sv]
/*
  port assertions for the command, sweep and list controller.
  assumes it is bound to scsl_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module scsl_ctrl_chk
(
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // command side
  input wire logic                cmdValid,
  input wire scsl_pkg::scsl_cmd_e cmdCode,
  input wire logic                cmdQuery,
  input wire logic                cmdHasArg,
  input wire logic [39:0]         cmdArg,
  input wire logic                lineEnd,
  // outputs watched
  input wire logic                reportValid,
  input wire scsl_pkg::scsl_cmd_e reportCmd,
  input wire logic                errorPulse,
  input wire logic [2:0]          baudSel,
  input wire logic [11:0]         refTrim,
  input wire logic                sweepActive,
  input wire logic                sweepStep,
  input wire logic                nvStore,
  input wire logic                nvErase
);
  import scsl_pkg::*;
  // ****************************************
  // assertions
  // ****************************************
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic take;
  // a command only counts once the line is closed
  assign take = cmdValid && lineEnd;

  baud_refuse_a :
    assert property (take && cmdCode == CMD_BAUD && cmdHasArg && !cmdQuery
      && cmdArg > 40'h7 |=> errorPulse) else $error("bad rate not refused");
  baud_cause_a :
    assert property (!$stable(baudSel) |-> $past(take))
      else $error("rate changed without command");
  report_cause_a :
    assert property (reportValid |-> $past(take))
      else $error("reply without closed line");
  query_reply_a :
    assert property (take && cmdCode == CMD_FREQ && (cmdQuery || !cmdHasArg)
      |=> reportValid && reportCmd == CMD_FREQ) else $error("no query reply");
  step_active_a :
    assert property (sweepStep |-> sweepActive || $past(sweepActive))
      else $error("step outside sweep");
  step_pulse_a :
    assert property (sweepStep |=> !sweepStep) else $error("step too long");
  mode_halt_a :
    assert property (take && cmdCode == CMD_MODE && cmdHasArg && !cmdQuery
      && (cmdArg == 40'h0 || cmdArg == 40'h2) |-> ##3 !sweepActive)
      else $error("sweep kept after mode change");
  trim_kept_a :
    assert property (refTrim == TRIM_RST) else $error("trim changed");
  store_pulse_a :
    assert property (take && cmdCode == CMD_STORE && !cmdQuery |=> nvStore)
      else $error("store not issued");
  erase_pulse_a :
    assert property (take && cmdCode == CMD_ERASE && !cmdQuery |=> nvErase)
      else $error("erase not issued");
endmodule : scsl_ctrl_chk

bind scsl_ctrl scsl_ctrl_chk chk (.clk(clk), .rst_b(rst_b),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdQuery(cmdQuery),
  .cmdHasArg(cmdHasArg), .cmdArg(cmdArg), .lineEnd(lineEnd),
  .reportValid(reportValid), .reportCmd(reportCmd),
  .errorPulse(errorPulse), .baudSel(baudSel), .refTrim(refTrim),
  .sweepActive(sweepActive), .sweepStep(sweepStep),
  .nvStore(nvStore), .nvErase(nvErase));

// [tb/scsl_nv_model.sv]
/*
  non-volatile image model facing the controller.
  assumes store captures the live output frequency; image survives reset.
*/
`timescale 1ns/1ps
module scsl_nv_model
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // requests
  input wire logic        nvStore,
  input wire logic        nvErase,
  input wire logic        nvLoadReq,
  input wire logic [39:0] curFreq,
  // image out
  output logic            nvLoadValid,
  output logic [39:0]     nvFreq,
  output logic [1:0]      nvMode,
  output logic            nvRun
);
  import scsl_pkg::*;
  logic [39:0] imgFreq = FREQ_RST_HZ;
  logic [1:0]  waitCnt;
  logic        busy;
  always @(posedge clk)
  begin
    nvLoadValid <= 1'b0;
    if (!rst_b)
      busy <= 1'b0;
    if (nvStore)
      imgFreq <= curFreq;
    if (nvErase)
      imgFreq <= FREQ_RST_HZ;
    if (rst_b && nvLoadReq)
    begin
      busy <= 1'b1;
      waitCnt <= 2'h3;
    end
    else if (rst_b && busy)
    begin
      waitCnt <= waitCnt - 2'h1;
      busy <= (waitCnt != 2'h0);
      nvLoadValid <= (waitCnt == 2'h0);
    end
  end
  // outside a load the lines show junk, never the stale image
  assign nvFreq = nvLoadValid ? imgFreq : ~imgFreq;
  assign nvMode = nvLoadValid ? MODE_CW : 2'h3;
  assign nvRun  = !nvLoadValid;
endmodule : scsl_nv_model

// [tb/tb_scsl_ctrl.sv]
/*
  self-checking bench for the command, sweep and list controller.
  assumes 50 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/1ps
module tb_scsl_ctrl;
  import scsl_pkg::*;
  typedef struct {
    scsl_cmd_e c; logic q, ha, ng, rp, er; logic [39:0] a, d, f;
    logic [2:0] b; } scsl_row_s;
  localparam logic [39:0] GHZ = 40'h3B_9ACA_00;
  localparam logic [39:0] MHZ = LIST_INC_HZ;
  localparam logic [39:0] F33 = 40'h21 * GHZ;
  localparam logic [39:0] F20 = 40'h14 * GHZ;
  logic clk, rst_b, cmdValid, cmdQuery, cmdHasArg, cmdHasArg2, lineEnd;
  logic nvLoadValid, nvRun, trigPin, reportValid, errorPulse, statusLed;
  logic nvStore, nvErase, nvLoadReq, sweepActive, sweepStep;
  logic repSeen, errSeen;
  scsl_cmd_e cmdCode, reportCmd;
  logic [39:0] cmdArg, nvFreq, reportData, outFreq, dataSeen;
  logic [7:0] cmdArg2, outPower;
  logic [1:0] nvMode;
  logic [4:0] listSelPin;
  logic [2:0] baudSel;
  logic [11:0] refTrim;
  int numErrors, checksDone;
  scsl_row_s rows [13];

  scsl_ctrl uut (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdQuery(cmdQuery), .cmdHasArg(cmdHasArg),
    .cmdArg(cmdArg), .cmdArg2(cmdArg2), .cmdHasArg2(cmdHasArg2),
    .lineEnd(lineEnd), .nvLoadValid(nvLoadValid), .nvFreq(nvFreq),
    .nvMode(nvMode), .nvRun(nvRun), .trigPin(trigPin),
    .listSelPin(listSelPin), .reportValid(reportValid),
    .reportCmd(reportCmd), .reportData(reportData),
    .errorPulse(errorPulse), .baudSel(baudSel), .statusLed(statusLed),
    .nvStore(nvStore), .nvErase(nvErase), .nvLoadReq(nvLoadReq),
    .outFreq(outFreq), .outPower(outPower), .refTrim(refTrim),
    .sweepActive(sweepActive), .sweepStep(sweepStep));
  scsl_nv_model nv (.clk(clk), .rst_b(rst_b), .nvStore(nvStore),
    .nvErase(nvErase), .nvLoadReq(nvLoadReq), .curFreq(outFreq),
    .nvLoadValid(nvLoadValid), .nvFreq(nvFreq), .nvMode(nvMode),
    .nvRun(nvRun));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input scsl_cmd_e c, input logic q, input logic ha,
    input logic [39:0] a, input logic [7:0] a2, input logic ha2);
    @(negedge clk);
    {cmdCode, cmdQuery, cmdHasArg, cmdArg} = {c, q, ha, a};
    {cmdArg2, cmdHasArg2, cmdValid, lineEnd} = {a2, ha2, 2'h3};
    @(negedge clk);
    {cmdValid, lineEnd} = 2'h0;
    {repSeen, errSeen, dataSeen} = {reportValid, errorPulse, reportData};
    @(negedge clk);
  endtask : send

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #100000;
    numErrors++;
    complete_run();
  end

  initial
  begin
    {rst_b, cmdValid, cmdQuery, cmdHasArg, cmdHasArg2, lineEnd} = 6'h0;
    {cmdCode, cmdArg, cmdArg2, trigPin, listSelPin} = {CMD_NONE, 54'h0};
    rows = '{
      '{CMD_FREQ, 1, 0, 0, 1, 0, 0, FREQ_RST_HZ, FREQ_RST_HZ, 0},
      '{CMD_FREQ, 0, 1, 0, 0, 0, 40'h18 * GHZ, 0, 40'h18 * GHZ, 0},
      '{CMD_FREQ, 0, 1, 0, 0, 0, F33, 0, F33, 0},
      '{CMD_STEP, 0, 1, 0, 0, 0, 40'h5 * MHZ, 0, F33, 0},
      '{CMD_FREQ_UP, 0, 0, 0, 0, 0, 0, 0, F33 + 40'h5 * MHZ, 0},
      '{CMD_FREQ_DOWN, 0, 0, 0, 0, 0, 0, 0, F33, 0},
      '{CMD_OFFSET, 0, 1, 1, 0, 0, GHZ, 0, F33 - GHZ, 0},
      '{CMD_OFFSET, 0, 1, 0, 0, 1, 40'h1_0000_0000, 0, F33 - GHZ, 0},
      '{CMD_OFFSET, 0, 1, 0, 0, 0, 0, 0, F33, 0},
      '{CMD_BAUD, 0, 1, 0, 0, 1, 40'h8, 0, F33, 0},
      '{CMD_BAUD, 0, 1, 0, 0, 0, 40'h7, 0, F33, 7},
      '{CMD_BAUD, 1, 0, 0, 1, 0, 0, 40'hFF, F33, 7},
      '{CMD_IDENTIFY, 0, 0, 0, 1, 0, 0, 0, F33, 7}};
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    check(refTrim, TRIM_RST);
    check(outFreq, FREQ_RST_HZ);
    $display("reset test done");
    foreach (rows[i])
    begin
      send(rows[i].c, rows[i].q, rows[i].ha, rows[i].a, 8'h0, rows[i].ng);
      check(repSeen, rows[i].rp);
      check(errSeen, rows[i].er);
      if (rows[i].rp)
        check(dataSeen, rows[i].d);
      check(outFreq, rows[i].f);
      check(baudSel, rows[i].b);
      $display("row %0d done", i);
    end
    // no line end, nothing happens
    @(negedge clk);
    {cmdCode, cmdHasArg, cmdArg, cmdValid} = {CMD_FREQ, 1'b1, F20, 1'b1};
    @(negedge clk);
    cmdValid = 1'b0;
    repeat (3) @(negedge clk);
    check(outFreq, F33);
    send(CMD_RESTORE, 0, 0, 0, 0, 0);
    check(outFreq, FREQ_RST_HZ);
    send(CMD_FREQ, 0, 1, 40'h15 * GHZ, 0, 0);
    send(CMD_STORE, 0, 0, 0, 0, 0);
    send(CMD_FREQ, 0, 1, 40'h16 * GHZ, 0, 0);
    send(CMD_RECALL, 0, 0, 0, 0, 0);
    for (int n = 0; n < 20 && outFreq !== 40'h15 * GHZ; n++) @(negedge clk);
    check(outFreq, 40'h15 * GHZ);
    send(CMD_ERASE, 0, 0, 0, 0, 0);
    send(CMD_FREQ, 0, 1, F33, 0, 0);
    send(CMD_RECALL, 0, 0, 0, 0, 0);
    repeat (12) @(negedge clk);
    check(outFreq, FREQ_RST_HZ);
    send(CMD_IDENTIFY, 0, 1, 40'h2, 0, 0);
    for (int n = 0; n < 10 && statusLed !== 1'b1; n++) @(negedge clk);
    check(statusLed, 1'b1);
    $display("store and identify tests done");
    send(CMD_MODE, 0, 1, 40'h1, 0, 0);
    send(CMD_START, 0, 1, F20, 0, 0);
    send(CMD_STOP, 0, 1, F20 + 40'hA * MHZ, 0, 0);
    send(CMD_STEP, 0, 1, MHZ, 0, 0);
    send(CMD_RETRACE, 0, 1, 0, 0, 0);
    send(CMD_TRIG_MODE, 0, 1, 40'h3, 0, 0);
    send(CMD_GO, 0, 0, 0, 0, 0);
    repeat (6) @(negedge clk);
    for (int k = 1; k < 4; k++)
    begin
      trigPin = 1'b1;
      for (int n = 0; n < 10 && sweepStep !== 1'b1; n++) @(negedge clk);
      check(sweepStep, 1'b1);
      check(sweepActive, 1'b1);
      repeat (4) @(negedge clk);
      trigPin = 1'b0;
      check(outFreq, F20 + MHZ * k);
      repeat (4) @(negedge clk);
    end
    send(CMD_TRIG_MODE, 0, 1, 40'h1, 0, 0);
    send(CMD_CEASE, 0, 0, 0, 0, 0);
    check(sweepActive, 1'b0);
    send(CMD_GO, 0, 0, 0, 0, 0);
    repeat (4) @(negedge clk);
    check(sweepActive, 1'b0);
    send(CMD_MAN_TRIG, 0, 0, 0, 0, 0);
    repeat (3) @(negedge clk);
    check(sweepActive, 1'b1);
    check(outFreq, F20);
    send(CMD_MODE, 0, 1, 40'h2, 0, 0);
    check(sweepActive, 1'b0);
    foreach (rows[k])
    begin
      listSelPin = 5'(k * 5'hB);
      repeat (6) @(negedge clk);
      check(outFreq, LIST_BASE_HZ + MHZ * listSelPin);
    end
    send(CMD_POWER, 0, 1, 40'h12, 0, 0);
    send(CMD_LIST, 0, 1, 40'h542E * MHZ, 8'h05, 0);
    listSelPin = 5'h05;
    repeat (6) @(negedge clk);
    check(outFreq, 40'h542E * MHZ);
    check(outPower, 8'h12);
    $display("sweep and list tests done");
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check(baudSel, BAUD_RST);
    check(outFreq, FREQ_RST_HZ);
    $display("second reset test done");
    complete_run();
  end
endmodule : tb_scsl_ctrl
